// ### hdl/scratchpad_pkg.sv
// Constants and types for the protected scratchpad controller
package scratchpad_pkg;
    localparam logic [7:0]  CMD_WRITE_SP  = 8'h0F;
    localparam logic [7:0]  CMD_READ_SP   = 8'hAA;
    localparam logic [7:0]  CMD_COPY_SP   = 8'h99;
    localparam logic [7:0]  CMD_READ_MEM  = 8'h69;
    localparam logic [7:0]  CMD_READ_VER  = 8'hCC;
    localparam logic [7:0]  PW_ENABLE_ON  = 8'hAA;
    localparam logic [7:0]  PW_ENABLE_RST = 8'h00;
    localparam logic [7:0]  COPY_OK_BYTE  = 8'hAA;
    localparam logic [7:0]  IDLE_BYTE     = 8'hFF;
    // Arbitrary revision value
    localparam logic [2:0]  REVISION      = 3'h0;
    localparam logic [15:0] ADDR_PW_READ  = 16'h7FC0;
    localparam logic [15:0] ADDR_PW_FULL  = 16'h7FC8;
    localparam logic [15:0] ADDR_PW_CTRL  = 16'h7FD0;
    localparam logic [11:0] PW_AREA       = 12'h7FC;
    localparam logic [5:0]  SP_LAST       = 6'h3F;
    localparam logic [15:0] CRC_POLY      = 16'hA001;
    localparam logic [15:0] CRC_RESET     = 16'h0000;
    localparam int          ST_ACCEPT_BIT = 7;
    localparam int          ST_PARTIAL_BIT = 6;
    localparam logic [2:0]  PH_TA_LO      = 3'h0;
    localparam logic [2:0]  PH_TA_HI      = 3'h1;
    localparam logic [2:0]  PH_STATUS     = 3'h2;
    localparam logic [2:0]  PH_DATA       = 3'h3;
    localparam logic [2:0]  PH_CRC_LO     = 3'h4;
    localparam logic [2:0]  PH_CRC_HI     = 3'h5;
    localparam logic [2:0]  PH_DONE       = 3'h6;
    localparam logic [2:0]  PW_LAST       = 3'h7;
    localparam logic [2:0]  VER_COPIES    = 3'h2;

    typedef enum logic [11:0] {
        S_IDLE    = 12'h001,
        S_CMD     = 12'h002,
        S_ADDR_LO = 12'h004,
        S_ADDR_HI = 12'h008,
        S_WDATA   = 12'h010,
        S_RSEND   = 12'h020,
        S_CAUTH   = 12'h040,
        S_CPASS   = 12'h080,
        S_COPY    = 12'h100,
        S_RESULT  = 12'h200,
        S_MPASS   = 12'h400,
        S_VERSION = 12'h800
    } state_t;
endpackage : scratchpad_pkg

// ### hdl/crc16_step.sv
// One byte step of the reflected CRC16 generator
`timescale 1ns/10ps
`default_nettype none
module crc16_step (
    input  wire logic [15:0] crcIn,
    input  wire logic [7:0]  dataIn,
    output logic      [15:0] crcOut
);
    always_comb begin
        logic [15:0] c;
        c = crcIn;
        // Bits enter least significant first
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ dataIn[i]) begin
                c = (c >> 1) ^ scratchpad_pkg::CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        crcOut = c;
    end
endmodule : crc16_step
`default_nettype wire

// ### hdl/protected_eeprom_scratchpad_ctrl.sv
// Protected scratchpad write, read, copy and password gate
`timescale 1ns/10ps
`default_nettype none
module protected_eeprom_scratchpad_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        frameStart,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxPartial,
    input  wire logic        txReq,
    input  wire logic        powerLoss,
    output logic             txValid,
    output logic      [7:0]  txData,
    output logic             memWrite,
    output logic      [14:0] memAddr,
    output logic      [7:0]  memWdata,
    output logic             readGrant,
    output logic      [14:0] readAddr
);
    typedef struct packed {
        scratchpad_pkg::state_t state;
        logic [7:0]             cmd;
        logic [15:0]            ta;
        logic                   copyAcceptedFlag;
        logic                   partialFlag;
        logic [5:0]             endOff;
        logic [63:0][7:0]       scratch;
        logic [15:0]            crc;
        logic [5:0]             idx;
        logic [2:0]             cnt;
        logic                   full;
        logic                   authOk;
        logic                   copyOk;
        logic [7:0][7:0]        shift;
        logic [7:0]             passwordEnablePattern;
        logic [7:0][7:0]        pwRead;
        logic [7:0][7:0]        pwFull;
        logic                   pwrMeta;
        logic                   pwrSeen;
        logic                   txValid;
        logic [7:0]             txData;
        logic                   memWrite;
        logic [14:0]            memAddr;
        logic [7:0]             memWdata;
        logic                   readGrant;
        logic [14:0]            readAddr;
    } regs_t;

    regs_t       st;
    regs_t       next_st;
    logic [7:0]  sendByte;
    logic [7:0]  feedByte;
    logic [15:0] crcAfter;
    logic [7:0]  statusByte;

    // Status built from internal state only
    assign statusByte = {st.copyAcceptedFlag, st.partialFlag, st.endOff};

    always_comb begin
        case (st.cnt)
            scratchpad_pkg::PH_TA_LO:  sendByte = st.ta[7:0];
            scratchpad_pkg::PH_TA_HI:  sendByte = st.ta[15:8];
            scratchpad_pkg::PH_STATUS: sendByte = statusByte;
            scratchpad_pkg::PH_DATA:   sendByte = st.scratch[st.idx];
            scratchpad_pkg::PH_CRC_LO: sendByte = ~st.crc[7:0];
            scratchpad_pkg::PH_CRC_HI: sendByte = ~st.crc[15:8];
            default:                   sendByte = scratchpad_pkg::IDLE_BYTE;
        endcase
    end

    assign feedByte = (st.state == scratchpad_pkg::S_RSEND) ? sendByte
                                                              : rxData;

    crc16_step u_crc (
        .crcIn  (st.crc),
        .dataIn (feedByte),
        .crcOut (crcAfter)
    );

    // Exact match, bypassed when protection is off
    function automatic logic pwOk(input logic [7:0] enable,
                                  input logic [63:0] pat,
                                  input logic [63:0] pw);
        pwOk = (enable != scratchpad_pkg::PW_ENABLE_ON) || (pat == pw);
    endfunction : pwOk

    always_comb begin
        logic [15:0] newTa;
        logic [63:0] pat;
        logic [15:0] cAddr;
        logic [7:0]  enPat;
        newTa = {1'b0, rxData[6:0], st.ta[7:0]};
        pat = {rxData, st.shift[7:1]};
        cAddr = {st.ta[15:6], st.idx};
        enPat = st.passwordEnablePattern;
        next_st = st;
        next_st.txValid = 1'b0;
        next_st.memWrite = 1'b0;
        next_st.readGrant = 1'b0;
        next_st.pwrMeta = powerLoss;
        next_st.pwrSeen = st.pwrMeta;
        if (frameStart) begin
            next_st.state = scratchpad_pkg::S_CMD;
            next_st.crc = scratchpad_pkg::CRC_RESET;
        end else begin
            unique case (st.state)
                scratchpad_pkg::S_IDLE, scratchpad_pkg::S_RESULT: begin
                    if (txReq) begin
                        next_st.txValid = 1'b1;
                        next_st.txData = st.copyOk
                            ? scratchpad_pkg::COPY_OK_BYTE
                            : scratchpad_pkg::IDLE_BYTE;
                    end
                end
                scratchpad_pkg::S_CMD: begin
                    if (rxValid) begin
                        next_st.crc = crcAfter;
                        next_st.cmd = rxData;
                        next_st.cnt = scratchpad_pkg::PH_TA_LO;
                        next_st.copyOk = 1'b0;
                        next_st.authOk = 1'b1;
                        next_st.idx = st.ta[5:0];
                        case (rxData)
                            scratchpad_pkg::CMD_WRITE_SP: begin
                                next_st.copyAcceptedFlag = 1'b0;
                                next_st.state = scratchpad_pkg::S_ADDR_LO;
                            end
                            scratchpad_pkg::CMD_READ_MEM:
                                next_st.state = scratchpad_pkg::S_ADDR_LO;
                            scratchpad_pkg::CMD_READ_SP:
                                next_st.state = scratchpad_pkg::S_RSEND;
                            scratchpad_pkg::CMD_COPY_SP:
                                next_st.state = scratchpad_pkg::S_CAUTH;
                            scratchpad_pkg::CMD_READ_VER:
                                next_st.state = scratchpad_pkg::S_VERSION;
                            default:
                                next_st.state = scratchpad_pkg::S_IDLE;
                        endcase
                    end
                end
                scratchpad_pkg::S_ADDR_LO: begin
                    if (rxValid) begin
                        next_st.ta[7:0] = rxData;
                        next_st.crc = crcAfter;
                        next_st.state = scratchpad_pkg::S_ADDR_HI;
                    end
                end
                scratchpad_pkg::S_ADDR_HI: begin
                    if (rxValid) begin
                        if (newTa[15:4] == scratchpad_pkg::PW_AREA) begin
                            newTa[2:0] = 3'h0;
                        end
                        // Top bit already dropped in newTa
                        next_st.ta = newTa;
                        next_st.crc = crcAfter;
                        next_st.idx = newTa[5:0];
                        next_st.full = 1'b0;
                        next_st.cnt = scratchpad_pkg::PH_CRC_LO;
                        next_st.state =
                            (st.cmd == scratchpad_pkg::CMD_WRITE_SP)
                            ? scratchpad_pkg::S_WDATA
                            : scratchpad_pkg::S_MPASS;
                        if (st.cmd != scratchpad_pkg::CMD_WRITE_SP) begin
                            next_st.cnt = 3'h0;
                        end
                    end
                end
                scratchpad_pkg::S_WDATA: begin
                    // Fill from offset, stop after 3Fh
                    if (rxValid && !st.full) begin
                        next_st.scratch[st.idx] = rxData;
                        next_st.endOff = st.idx;
                        next_st.partialFlag = 1'b0;
                        next_st.crc = crcAfter;
                        if (st.idx == scratchpad_pkg::SP_LAST) begin
                            next_st.full = 1'b1;
                        end else begin
                            next_st.idx = st.idx + 6'h01;
                        end
                    end
                    if (rxPartial) begin
                        next_st.partialFlag = 1'b1;
                    end
                    // Inverted CRC only after a full scratchpad
                    if (txReq) begin
                        next_st.txValid = 1'b1;
                        next_st.txData = st.full
                            ? sendByte : scratchpad_pkg::IDLE_BYTE;
                        if (st.full && st.cnt != scratchpad_pkg::PH_DONE) begin
                            next_st.cnt = st.cnt + 3'h1;
                        end
                    end
                end
                scratchpad_pkg::S_RSEND: begin
                    if (txReq) begin
                        next_st.txValid = 1'b1;
                        next_st.txData = sendByte;
                        if (st.cnt <= scratchpad_pkg::PH_DATA) begin
                            next_st.crc = crcAfter;
                        end
                        if (st.cnt == scratchpad_pkg::PH_DATA &&
                            st.idx != scratchpad_pkg::SP_LAST) begin
                            next_st.idx = st.idx + 6'h01;
                        end else if (st.cnt != scratchpad_pkg::PH_DONE) begin
                            next_st.cnt = st.cnt + 3'h1;
                        end
                    end
                end
                scratchpad_pkg::S_CAUTH: begin
                    if (rxValid) begin
                        // Pattern must echo address and status
                        if (rxData != sendByte) begin
                            next_st.authOk = 1'b0;
                        end
                        next_st.cnt = st.cnt + 3'h1;
                        if (st.cnt == scratchpad_pkg::PH_STATUS) begin
                            next_st.cnt = 3'h0;
                            next_st.state = scratchpad_pkg::S_CPASS;
                        end
                    end
                end
                scratchpad_pkg::S_CPASS, scratchpad_pkg::S_MPASS: begin
                    if (rxValid) begin
                        next_st.shift = pat;
                        next_st.cnt = st.cnt + 3'h1;
                        if (st.cnt == scratchpad_pkg::PW_LAST) begin
                            next_st.state = scratchpad_pkg::S_RESULT;
                            // Enable byte taken as now stored
                            if (st.state == scratchpad_pkg::S_CPASS) begin
                                if (st.authOk && !st.partialFlag &&
                                    pwOk(enPat, pat, st.pwFull) &&
                                    st.ta[5:0] <= st.endOff &&
                                    {st.ta[15:6], st.endOff} <=
                                        scratchpad_pkg::ADDR_PW_CTRL) begin
                                    next_st.copyAcceptedFlag = 1'b1;
                                    next_st.idx = st.ta[5:0];
                                    next_st.state = scratchpad_pkg::S_COPY;
                                end
                            // Either password opens a memory read
                            end else if (st.ta < scratchpad_pkg::ADDR_PW_READ &&
                                         (pwOk(enPat, pat, st.pwRead) ||
                                          pwOk(enPat, pat, st.pwFull))) begin
                                next_st.readGrant = 1'b1;
                                next_st.readAddr = st.ta[14:0];
                            end
                        end
                    end
                end
                scratchpad_pkg::S_COPY: begin
                    next_st.memWrite = 1'b1;
                    next_st.memAddr = cAddr[14:0];
                    next_st.memWdata = st.scratch[st.idx];
                    if (cAddr[15:3] == scratchpad_pkg::ADDR_PW_READ[15:3]) begin
                        next_st.pwRead[st.idx[2:0]] = st.scratch[st.idx];
                    end
                    if (cAddr[15:3] == scratchpad_pkg::ADDR_PW_FULL[15:3]) begin
                        next_st.pwFull[st.idx[2:0]] = st.scratch[st.idx];
                    end
                    if (cAddr == scratchpad_pkg::ADDR_PW_CTRL) begin
                        next_st.passwordEnablePattern = st.scratch[st.idx];
                    end
                    if (st.idx == st.endOff) begin
                        next_st.copyOk = 1'b1;
                        next_st.state = scratchpad_pkg::S_RESULT;
                    end else begin
                        next_st.idx = st.idx + 6'h01;
                    end
                end
                scratchpad_pkg::S_VERSION: begin
                    if (txReq) begin
                        next_st.txValid = 1'b1;
                        next_st.txData = scratchpad_pkg::IDLE_BYTE;
                        if (st.cnt < scratchpad_pkg::VER_COPIES) begin
                            next_st.txData = {scratchpad_pkg::REVISION, 5'h00};
                            next_st.cnt = st.cnt + 3'h1;
                        end
                    end
                end
            endcase
        end
        // Power loss wins over any clear this cycle
        if (st.pwrSeen) begin
            next_st.partialFlag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.state <= scratchpad_pkg::S_IDLE;
            st.passwordEnablePattern <= scratchpad_pkg::PW_ENABLE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign txValid   = st.txValid;
    assign txData    = st.txData;
    assign memWrite  = st.memWrite;
    assign memAddr   = st.memAddr;
    assign memWdata  = st.memWdata;
    assign readGrant = st.readGrant;
    assign readAddr  = st.readAddr;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_accept_clear_write: assert property (
        st.state == scratchpad_pkg::S_CMD && rxValid && !frameStart &&
        rxData == scratchpad_pkg::CMD_WRITE_SP |=> !st.copyAcceptedFlag)
        else $error("accepted flag not cleared by write command");
    a_partial_set: assert property (
        st.state == scratchpad_pkg::S_WDATA && rxPartial && !frameStart
        |=> st.partialFlag)
        else $error("partial flag not set");
    a_addr_top_clear: assert property (
        !st.ta[15])
        else $error("target address top bit set");
    a_pw_align_zero: assert property (
        st.state == scratchpad_pkg::S_WDATA &&
        st.ta[15:4] == scratchpad_pkg::PW_AREA |-> st.ta[2:0] == 3'h0)
        else $error("password address not aligned");
    a_sp_data_store: assert property (
        st.state == scratchpad_pkg::S_WDATA && rxValid && !st.full &&
        !frameStart |=> st.scratch[$past(st.idx)] == $past(rxData) &&
        st.endOff == $past(st.idx))
        else $error("scratchpad byte or ending offset wrong");
    a_read_preamble: assert property (
        st.state == scratchpad_pkg::S_RSEND && st.cnt == 3'h0 && txReq &&
        !frameStart |=> txValid && txData == $past(st.ta[7:0]))
        else $error("read scratchpad did not open with low address");
    a_copy_needs_auth: assert property (
        $rose(st.state == scratchpad_pkg::S_COPY) |->
        $past(st.authOk) && !$past(st.partialFlag) && st.copyAcceptedFlag)
        else $error("copy started without authorization");
    a_revision_low: assert property (
        st.state == scratchpad_pkg::S_VERSION && st.cnt == 3'h0 && txReq &&
        !frameStart |=> txValid && txData[4:0] == 5'h00)
        else $error("revision low bits not zero");
    a_copy_in_range: assert property (
        memWrite |-> {1'b0, memAddr} <= scratchpad_pkg::ADDR_PW_CTRL)
        else $error("copy into reserved space");
    a_read_user_only: assert property (
        readGrant |-> {1'b0, readAddr} < scratchpad_pkg::ADDR_PW_READ)
        else $error("memory read outside user pages");
endmodule : protected_eeprom_scratchpad_ctrl
`default_nettype wire

// ### tb/link_master_model.sv
// Link master model driving the byte port
`timescale 1ns/10ps
`default_nettype none
module link_master_model (
    input  wire logic       clk_sys,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output logic            frameStart,
    output logic            rxValid,
    output logic      [7:0] rxData,
    output logic            rxPartial,
    output logic            txReq
);
    initial begin
        frameStart = 1'b0;
        rxValid    = 1'b0;
        rxPartial  = 1'b0;
        txReq      = 1'b0;
        rxData     = 8'hFF;
    end
    task automatic frame();
        @(posedge clk_sys) #1;
        frameStart = 1'b1;
        @(posedge clk_sys) #1;
        frameStart = 1'b0;
    endtask : frame
    task automatic put(input logic [7:0] b);
        @(posedge clk_sys) #1;
        rxValid = 1'b1;
        rxData  = b;
        @(posedge clk_sys) #1;
        rxValid = 1'b0;
        // Released data is inverted so stale values never pass
        rxData  = ~b;
    endtask : put
    task automatic cut();
        @(posedge clk_sys) #1;
        rxPartial = 1'b1;
        @(posedge clk_sys) #1;
        rxPartial = 1'b0;
    endtask : cut
    // Never requested together with a byte strobe
    task automatic get(output logic [7:0] b);
        @(posedge clk_sys) #1;
        txReq = 1'b1;
        @(posedge clk_sys) #1;
        txReq = 1'b0;
        for (int i = 0; i < 4 && txValid !== 1'b1; i++) @(posedge clk_sys) #1;
        b = (txValid === 1'b1) ? txData : 8'hXX;
    endtask : get
endmodule : link_master_model
`default_nettype wire

// ### tb/protected_eeprom_scratchpad_ctrl_test.sv
// Self-checking bench for the scratchpad controller
`timescale 1ns/10ps
`default_nettype none
module protected_eeprom_scratchpad_ctrl_test;
    logic        clk_sys, rst_n, powerLoss, frameStart, rxValid, rxPartial;
    logic        txReq, txValid, memWrite, readGrant;
    logic [7:0]  rxData, txData, memWdata, b, lastData;
    logic [14:0] memAddr, readAddr, lastAddr;
    logic [15:0] crc;
    int          error_cnt, compares, writes, grants;
    protected_eeprom_scratchpad_ctrl uut (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .frameStart (frameStart),
        .rxValid    (rxValid),
        .rxData     (rxData),
        .rxPartial  (rxPartial),
        .txReq      (txReq),
        .powerLoss  (powerLoss),
        .txValid    (txValid),
        .txData     (txData),
        .memWrite   (memWrite),
        .memAddr    (memAddr),
        .memWdata   (memWdata),
        .readGrant  (readGrant),
        .readAddr   (readAddr)
    );
    link_master_model lm (
        .clk_sys    (clk_sys),
        .txValid    (txValid),
        .txData     (txData),
        .frameStart (frameStart),
        .rxValid    (rxValid),
        .rxData     (rxData),
        .rxPartial  (rxPartial),
        .txReq      (txReq)
    );
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (memWrite === 1'b1) begin
            writes++;
            lastAddr = memAddr;
            lastData = memWdata;
        end
        if (readGrant === 1'b1) begin
            grants++;
            lastAddr = readAddr;
        end
    end
    function automatic logic [15:0] crcB(logic [15:0] c, logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ scratchpad_pkg::CRC_POLY : c >> 1;
        return c;
    endfunction : crcB
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tx(input logic [7:0] d);
        lm.put(d);
        crc = crcB(crc, d);
    endtask : tx
    task automatic wr(input logic [7:0] lo, hi, d0, input int n);
        lm.frame();
        crc = 16'h0000;
        tx(8'h0F);
        tx(lo);
        tx(hi);
        for (int i = 0; i < n; i++) tx(d0 + 8'(i));
    endtask : wr
    task automatic rdsp(input logic [7:0] st);
        logic [7:0] e [7];
        e = '{8'h3C, 8'h10, st, 8'hD0, 8'hD1, 8'hD2, 8'hD3};
        lm.frame();
        lm.put(8'hAA);
        crc = crcB(16'h0000, 8'hAA);
        for (int i = 0; i < 7; i++) begin
            lm.get(b);
            chk(b, e[i]);
            crc = crcB(crc, e[i]);
        end
        // Braces keep the inversion at eight bits
        lm.get(b);
        chk(b, {~crc[7:0]});
        lm.get(b);
        chk(b, {~crc[15:8]});
        $display("Test read scratchpad %h done", st);
    endtask : rdsp
    task automatic cpy(input logic [7:0] lo, hi, st, pw, input int n,
                       input logic [7:0] res);
        writes = 0;
        lm.frame();
        lm.put(8'h99);
        lm.put(lo);
        lm.put(hi);
        lm.put(st);
        repeat (8) lm.put(pw);
        repeat (70) @(posedge clk_sys) #1;
        lm.get(b);
        chk(b, res);
        chk(16'(writes), 16'(n));
        $display("Test copy %h done", st);
    endtask : cpy
    task automatic rdm(input logic [7:0] lo, hi, pw, input int n);
        grants = 0;
        lm.frame();
        lm.put(8'h69);
        lm.put(lo);
        lm.put(hi);
        repeat (8) lm.put(pw);
        repeat (4) @(posedge clk_sys) #1;
        chk(16'(grants), 16'(n));
        if (n > 0) chk({1'b0, lastAddr}, {hi[6:0], lo});
        $display("Test read memory %h%h done", hi, lo);
    endtask : rdm
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #300000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        rst_n     = 1'b0;
        powerLoss = 1'b0;
        error_cnt = 0;
        compares  = 0;
        writes    = 0;
        grants    = 0;
        repeat (2) @(posedge clk_sys) #1;
        rst_n = 1'b1;
        wr(8'h3C, 8'h10, 8'hD0, 4);
        lm.put(8'h55);
        lm.get(b);
        chk(b, {~crc[7:0]});
        lm.get(b);
        chk(b, {~crc[15:8]});
        $display("Test write scratchpad done");
        rdsp(8'h3F);
        // A cut byte only counts inside a write frame
        wr(8'h3C, 8'h10, 8'hD0, 4);
        lm.cut();
        rdsp(8'h7F);
        cpy(8'h3C, 8'h10, 8'h7F, 8'h00, 0, 8'hFF);
        wr(8'h3C, 8'h10, 8'hD0, 4);
        rdsp(8'h3F);
        cpy(8'h3C, 8'h10, 8'h3F, 8'h00, 4, 8'hAA);
        chk({1'b0, lastAddr}, 16'h103F);
        chk({8'h00, lastData}, 16'h00D3);
        rdsp(8'hBF);
        powerLoss = 1'b1;
        repeat (4) @(posedge clk_sys) #1;
        powerLoss = 1'b0;
        rdsp(8'hFF);
        rdm(8'h3C, 8'h10, 8'h5A, 1);
        rdm(8'hC0, 8'h7F, 8'h00, 0);
        lm.frame();
        lm.put(8'hCC);
        lm.put(8'h00);
        lm.put(8'h00);
        repeat (2) begin
            lm.get(b);
            chk(b, {scratchpad_pkg::REVISION, 5'h00});
        end
        lm.get(b);
        chk(b, 8'hFF);
        $display("Test read version done");
        wr(8'hD0, 8'h7F, 8'hAA, 1);
        cpy(8'hD0, 8'h7F, 8'h10, 8'h00, 1, 8'hAA);
        wr(8'h00, 8'h00, 8'h11, 1);
        rdm(8'h3C, 8'h10, 8'hFF, 0);
        rdm(8'h3C, 8'h10, 8'h00, 1);
        end_of_test();
    end
endmodule : protected_eeprom_scratchpad_ctrl_test
`default_nettype wire
